// ==== core/tcr_pin_cond.sv ====
// Purpose: synchronise a pin, optional noise filter, edge select
// Assumes: pin is asynchronous to clock_in
// Notes: filtered path adds SAMPLES cycles of delay
module tcr_pin_cond import tcr_pkg::*; #(
   parameter int SAMPLES = FILT_SAMPLES
) (
   input wire logic clock_in,
   input wire logic resetn_in,
   input wire logic pin_in,
   tcr_evt_if.cond evt
);
   typedef struct packed {
      logic sync1;
      logic sync2;
      logic [SAMPLES-1:0] samp;
      logic filt;
      logic filt_d;
   } tcr_cond_t;
   tcr_cond_t s_ff, nxt_s;

   if (SAMPLES < 2) begin : g_chk
      $error("tcr_pin_cond needs at least two samples");
   end

   always_comb begin
      nxt_s = s_ff;
      nxt_s.sync1 = pin_in;
      nxt_s.sync2 = s_ff.sync1;
      nxt_s.samp = {s_ff.samp[SAMPLES-2:0], s_ff.sync2};
      nxt_s.filt_d = s_ff.filt;
      if (!evt.filt_en) begin
         nxt_s.filt = s_ff.sync2;
      end else if (&s_ff.samp) begin
         nxt_s.filt = 1'b1;
      end else if (~|s_ff.samp) begin
         nxt_s.filt = 1'b0;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign evt.event_p = (s_ff.filt != s_ff.filt_d) &&
      (s_ff.filt == evt.rise_sel);

   AST_FILT_STABLE: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      $past(evt.filt_en) && $changed(s_ff.filt) |->
      $past(s_ff.samp) == {SAMPLES{s_ff.filt}})
      else $error("filter output changed without equal samples");
   AST_EDGE_POL: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      evt.event_p && !$past(evt.filt_en) && !$past(evt.filt_en, 2) |->
      $past(pin_in, 3) == evt.rise_sel && $past(pin_in, 4) != evt.rise_sel)
      else $error("capture edge of wrong polarity");
endmodule

// ==== core/tcr_prescaler.sv ====
// Purpose: free-running I/O clock prescaler and tick select
// Assumes: clock select codes from the package
// Notes: tick is one cycle wide
module tcr_prescaler import tcr_pkg::*; #(
   parameter int WIDTH = PRE_WIDTH
) (
   input wire logic clock_in,
   input wire logic resetn_in,
   input wire logic [2:0] clock_sel_in,
   output logic tick_out
);
   typedef struct packed {
      logic [WIDTH-1:0] cnt;
   } tcr_pre_t;
   tcr_pre_t s_ff, nxt_s;

   if (WIDTH != PRE_WIDTH) begin : g_chk
      $error("tcr_prescaler width must match the divide masks");
   end

   always_comb begin
      nxt_s.cnt = s_ff.cnt + 1'b1;
   end

   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   always_comb begin
      case (clock_sel_in)
         CS_DIV1: tick_out = 1'b1;
         CS_DIV8: tick_out = &(s_ff.cnt | ~PRE_MASK_8);
         CS_DIV64: tick_out = &(s_ff.cnt | ~PRE_MASK_64);
         CS_DIV256: tick_out = &(s_ff.cnt | ~PRE_MASK_256);
         CS_DIV1024: tick_out = &(s_ff.cnt | ~PRE_MASK_1024);
         default: tick_out = 1'b0;
      endcase
   end
endmodule

// ==== core/tcr_timer16.sv ====
// Purpose: 16-bit timer with capture, two compares and CPU I/O registers
// Assumes: CPU I/O port sampled on clock_in; pins asynchronous
// Notes: read data appears the cycle after the read strobe
module tcr_timer16 import tcr_pkg::*; (
   input wire logic clock_in,
   input wire logic resetn_in,
   input wire logic [7:0] io_addr_in,
   input wire logic [7:0] io_wdata_in,
   input wire logic io_wr_in,
   input wire logic io_rd_in,
   output logic [7:0] io_rdata_out,
   input wire logic capture_input_pin_in,
   input wire logic ext_count_pin_in,
   input wire logic global_irq_en_in,
   input wire logic capture_vec_ack_in,
   input wire logic match_a_vec_ack_in,
   input wire logic match_b_vec_ack_in,
   input wire logic wrap_vec_ack_in,
   output logic capture_irq_out,
   output logic match_a_irq_out,
   output logic match_b_irq_out,
   output logic wrap_irq_out,
   output logic compare_output_pin_a_out,
   output logic compare_output_pin_b_out
);
   typedef struct packed {
      logic [7:0] temp;
      logic [15:0] cnt;
      logic [15:0] icr;
      logic [15:0] ocra;
      logic [15:0] ocrb;
      logic [7:0] ctla;
      logic [7:0] ctlb;
      logic [7:0] mask;
      logic capture_flag;
      logic ocfa;
      logic ocfb;
      logic tov;
      logic dn;
      logic blk;
      logic oca;
      logic ocb;
      logic [7:0] rdata;
   } tcr_state_t;
   tcr_state_t s_ff, nxt_s;

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!resetn_in);

   tcr_evt_if cap_if ();
   tcr_evt_if cnt_if ();
   logic pre_tick;
   logic tick;
   logic [3:0] waveform_mode_sel;
   logic [2:0] clock_source_sel;
   logic [15:0] top;
   logic icr_top;
   logic pwm;
   logic phase;
   logic wr_cnt;
   logic force_wr;
   logic match_a;
   logic match_b;
   logic at_top;
   logic at_bottom;
   logic tog_a_ok;
   logic [7:0] flag_clr;

   assign waveform_mode_sel = {s_ff.ctlb[4:3], s_ff.ctla[1:0]};
   assign clock_source_sel = s_ff.ctlb[2:0];

   assign cap_if.filt_en = s_ff.ctlb[FILT_BIT];
   assign cap_if.rise_sel = s_ff.ctlb[EDGE_BIT];
   assign cnt_if.filt_en = 1'b0;
   assign cnt_if.rise_sel = clock_source_sel[0];

   tcr_pin_cond #(.SAMPLES(FILT_SAMPLES)) u_cap (
      .clock_in(clock_in),
      .resetn_in(resetn_in),
      .pin_in(capture_input_pin_in),
      .evt(cap_if.cond)
   );

   tcr_pin_cond #(.SAMPLES(FILT_SAMPLES)) u_cnt (
      .clock_in(clock_in),
      .resetn_in(resetn_in),
      .pin_in(ext_count_pin_in),
      .evt(cnt_if.cond)
   );

   tcr_prescaler #(.WIDTH(PRE_WIDTH)) u_pre (
      .clock_in(clock_in),
      .resetn_in(resetn_in),
      .clock_sel_in(clock_source_sel),
      .tick_out(pre_tick)
   );

   assign tick = pre_tick || (clock_source_sel[2:1] == 2'b11 &&
      cnt_if.event_p);

   // Counter top and mode class
   always_comb begin
      case (waveform_mode_sel)
         4'h1, 4'h5: top = TOP_8BIT;
         4'h2, 4'h6: top = TOP_9BIT;
         4'h3, 4'h7: top = TOP_10BIT;
         4'h4, 4'h9, 4'hB, 4'hF: top = s_ff.ocra;
         4'h8, 4'hA, 4'hC, 4'hE: top = s_ff.icr;
         default: top = TOP_MAX;
      endcase
   end
   assign icr_top = waveform_mode_sel inside {4'h8, 4'hA, 4'hC, 4'hE};
   assign pwm = !(waveform_mode_sel inside {4'h0, 4'h4, 4'hC});
   assign phase = waveform_mode_sel inside {4'h1, 4'h2, 4'h3, 4'h8,
      4'h9, 4'hA, 4'hB};
   assign tog_a_ok = waveform_mode_sel inside {4'h9, 4'hB, 4'hE, 4'hF};
   assign at_top = s_ff.cnt == top;
   assign at_bottom = s_ff.cnt == RESET_WORD;

   assign wr_cnt = io_wr_in && io_addr_in == ADDR_CNT_L;
   assign force_wr = io_wr_in && io_addr_in == ADDR_FORCE && !pwm;
   assign match_a = tick && !s_ff.blk && s_ff.cnt == s_ff.ocra;
   assign match_b = tick && !s_ff.blk && s_ff.cnt == s_ff.ocrb;
   assign flag_clr = (io_wr_in && io_addr_in == ADDR_FLAGS) ?
      io_wdata_in : RESET_BYTE;

   // Waveform pin action on a compare match
   function automatic logic oc_next(input logic cur, input logic [1:0] com,
      input logic is_pwm, input logic down, input logic tog_ok);
      logic v;
      v = cur;
      case (com)
         COM_TOGGLE: v = (!is_pwm || tog_ok) ? !cur : cur;
         COM_CLEAR: v = is_pwm && down;
         COM_SET: v = !(is_pwm && down);
         default: v = cur;
      endcase
      return v;
   endfunction

   always_comb begin
      nxt_s = s_ff;
      if (tick) begin
         nxt_s.blk = 1'b0;
      end
      // Counting sequence
      if (tick && phase) begin
         if (!s_ff.dn) begin
            nxt_s.dn = at_top;
            nxt_s.cnt = at_top ? s_ff.cnt - 1'b1 : s_ff.cnt + 1'b1;
         end else begin
            nxt_s.dn = !at_bottom;
            nxt_s.cnt = at_bottom ? s_ff.cnt + 1'b1 : s_ff.cnt - 1'b1;
         end
      end else if (tick) begin
         nxt_s.cnt = at_top ? RESET_WORD : s_ff.cnt + 1'b1;
      end
      // Output compare pins
      if (match_a) begin
         nxt_s.oca = oc_next(s_ff.oca, s_ff.ctla[7:6], pwm, s_ff.dn,
            tog_a_ok);
      end
      if (match_b) begin
         nxt_s.ocb = oc_next(s_ff.ocb, s_ff.ctla[5:4], pwm, s_ff.dn, 1'b0);
      end
      if (tick && pwm && !phase && at_top) begin
         if (s_ff.ctla[7]) begin
            nxt_s.oca = !s_ff.ctla[6];
         end
         if (s_ff.ctla[5]) begin
            nxt_s.ocb = !s_ff.ctla[4];
         end
      end
      if (force_wr && io_wdata_in[FORCE_A_BIT]) begin
         nxt_s.oca = oc_next(s_ff.oca, s_ff.ctla[7:6], 1'b0, 1'b0, 1'b0);
      end
      if (force_wr && io_wdata_in[FORCE_B_BIT]) begin
         nxt_s.ocb = oc_next(s_ff.ocb, s_ff.ctla[5:4], 1'b0, 1'b0, 1'b0);
      end
      // Flags: set wins over clear
      // vector or write-one clear
      nxt_s.capture_flag = s_ff.capture_flag && !capture_vec_ack_in &&
         !flag_clr[CAP_BIT];
      nxt_s.ocfa = s_ff.ocfa && !match_a_vec_ack_in && !flag_clr[MATCH_A_BIT];
      nxt_s.ocfb = s_ff.ocfb && !match_b_vec_ack_in && !flag_clr[MATCH_B_BIT];
      nxt_s.tov = s_ff.tov && !wrap_vec_ack_in && !flag_clr[WRAP_BIT];
      if (match_a) begin
         nxt_s.ocfa = 1'b1;
      end
      if (match_b) begin
         nxt_s.ocfb = 1'b1;
      end
      if (tick && (phase ? (s_ff.dn && at_bottom) :
         (pwm ? at_top : s_ff.cnt == TOP_MAX))) begin
         nxt_s.tov = 1'b1;
      end
      if (tick && icr_top && at_top) begin
         nxt_s.capture_flag = 1'b1;
      end
      if (cap_if.event_p && !icr_top) begin
         nxt_s.icr = s_ff.cnt;
         nxt_s.capture_flag = 1'b1;
      end
      // Register writes
      // shared high-byte latch
      if (io_wr_in) begin
         case (io_addr_in)
            ADDR_MASK: nxt_s.mask = io_wdata_in & MASK_WR_BITS;
            ADDR_CTRL_A: nxt_s.ctla = io_wdata_in & CTRL_A_WR_BITS;
            ADDR_CTRL_B: nxt_s.ctlb = io_wdata_in & CTRL_B_WR_BITS;
            ADDR_CNT_H, ADDR_ICR_H, ADDR_OCRA_H, ADDR_OCRB_H:
               nxt_s.temp = io_wdata_in;
            ADDR_CNT_L: begin
               nxt_s.cnt = {s_ff.temp, io_wdata_in};
               nxt_s.blk = 1'b1;
            end
            ADDR_ICR_L: nxt_s.icr = {s_ff.temp, io_wdata_in};
            ADDR_OCRA_L: nxt_s.ocra = {s_ff.temp, io_wdata_in};
            ADDR_OCRB_L: nxt_s.ocrb = {s_ff.temp, io_wdata_in};
            default: nxt_s.temp = s_ff.temp;
         endcase
      end
      // Register reads
      if (io_rd_in) begin
         case (io_addr_in)
            ADDR_MASK: nxt_s.rdata = s_ff.mask & MASK_WR_BITS;
            ADDR_CTRL_A: nxt_s.rdata = s_ff.ctla;
            ADDR_CTRL_B: nxt_s.rdata = s_ff.ctlb;
            ADDR_FORCE: nxt_s.rdata = RESET_BYTE;
            ADDR_FLAGS: nxt_s.rdata = {2'b00, s_ff.capture_flag, 2'b00,
               s_ff.ocfb, s_ff.ocfa, s_ff.tov};
            ADDR_CNT_L: begin
               nxt_s.rdata = s_ff.cnt[7:0];
               nxt_s.temp = s_ff.cnt[15:8];
            end
            ADDR_ICR_L: begin
               nxt_s.rdata = s_ff.icr[7:0];
               nxt_s.temp = s_ff.icr[15:8];
            end
            ADDR_OCRA_L: begin
               nxt_s.rdata = s_ff.ocra[7:0];
               nxt_s.temp = s_ff.ocra[15:8];
            end
            ADDR_OCRB_L: begin
               nxt_s.rdata = s_ff.ocrb[7:0];
               nxt_s.temp = s_ff.ocrb[15:8];
            end
            ADDR_CNT_H, ADDR_ICR_H, ADDR_OCRA_H, ADDR_OCRB_H:
               nxt_s.rdata = s_ff.temp;
            default: nxt_s.rdata = RESET_BYTE;
         endcase
      end
   end

   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign io_rdata_out = s_ff.rdata;
   assign compare_output_pin_a_out = s_ff.oca;
   assign compare_output_pin_b_out = s_ff.ocb;
   assign capture_irq_out = s_ff.mask[CAP_BIT] && global_irq_en_in &&
      s_ff.capture_flag;
   assign match_a_irq_out = s_ff.mask[MATCH_A_BIT] && global_irq_en_in &&
      s_ff.ocfa;
   assign match_b_irq_out = s_ff.mask[MATCH_B_BIT] && global_irq_en_in &&
      s_ff.ocfb;
   assign wrap_irq_out = s_ff.mask[WRAP_BIT] && global_irq_en_in && s_ff.tov;

   AST_CAPTURE_COPY: assert property (
      cap_if.event_p && !icr_top && !(io_wr_in && io_addr_in == ADDR_ICR_L)
      |=> s_ff.icr == $past(s_ff.cnt) && s_ff.capture_flag)
      else $error("capture did not copy counter or set flag");
   AST_CAPTURE_OFF: assert property (
      cap_if.event_p && icr_top && !io_wr_in |=> $stable(s_ff.icr))
      else $error("capture register loaded while used as top");
   AST_STOPPED: assert property (
      clock_source_sel == CS_STOP && !wr_cnt |=> $stable(s_ff.cnt))
      else $error("counter moved with no clock source");
   AST_PWM_NO_FORCE: assert property (
      pwm && io_wr_in && io_addr_in == ADDR_FORCE && !tick
      |=> $stable(compare_output_pin_a_out) &&
      $stable(compare_output_pin_b_out))
      else $error("force strobe acted in a PWM mode");
   AST_FORCE_NO_FLAG: assert property (
      force_wr && !tick |=> !$rose(s_ff.ocfa) && !$rose(s_ff.ocfb))
      else $error("force strobe set a match flag");
   AST_FORCE_READ_ZERO: assert property (
      io_rd_in && io_addr_in == ADDR_FORCE |=> io_rdata_out == 8'h00)
      else $error("force register read nonzero");
   AST_ATOMIC_WRITE: assert property (
      io_wr_in && io_addr_in == ADDR_OCRA_H ##1 !io_wr_in && !io_rd_in ##1
      io_wr_in && io_addr_in == ADDR_OCRA_L
      |=> s_ff.ocra == {$past(io_wdata_in, 3), $past(io_wdata_in)})
      else $error("16-bit write did not commit both bytes");
   AST_WRITE_BLOCKS: assert property (
      s_ff.blk && tick && !io_wr_in |=> !$rose(s_ff.ocfa) &&
      !$rose(s_ff.ocfb))
      else $error("match not blocked after counter write");
   AST_MASK_HIGH_ZERO: assert property (
      io_rd_in && io_addr_in == ADDR_MASK |=> io_rdata_out[7:6] == 2'b00)
      else $error("mask bits 7..6 read nonzero");
   AST_CAP_IRQ: assert property (
      $rose(capture_irq_out) && $past(global_irq_en_in) &&
      $past(s_ff.mask[CAP_BIT]) |-> $past(cap_if.event_p && !icr_top) ||
      $past(tick && icr_top && at_top))
      else $error("capture request without a capture event");
   AST_FLAG_CLEAR: assert property (
      s_ff.capture_flag && capture_vec_ack_in && !cap_if.event_p &&
      !(tick && icr_top && at_top) |=> !s_ff.capture_flag)
      else $error("capture flag not cleared by vector");
   AST_EXT_TICK: assert property (
      clock_source_sel[2:1] == 2'b11 && cnt_if.event_p && !io_wr_in &&
      waveform_mode_sel == 4'h0 |=> s_ff.cnt == $past(s_ff.cnt) + 16'h0001)
      else $error("external edge did not advance the counter");
   AST_MATCH_FLAG: assert property (
      tick && !s_ff.blk && s_ff.cnt == s_ff.ocra |=> s_ff.ocfa)
      else $error("compare match did not set its flag");
   AST_FORCE_TOGGLE: assert property (
      force_wr && io_wdata_in[FORCE_A_BIT] &&
      s_ff.ctla[7:6] == COM_TOGGLE && !tick |=>
      compare_output_pin_a_out != $past(compare_output_pin_a_out))
      else $error("forced match did not toggle channel A");
endmodule

// ==== inc/tcr_evt_if.sv ====
// Purpose: carries pin conditioning setup and the qualified edge event
// Assumes: one clock domain
// Notes: event is a one-cycle pulse
interface tcr_evt_if;
   logic filt_en;
   logic rise_sel;
   logic event_p;
   modport cfg (output filt_en, output rise_sel, input event_p);
   modport cond (input filt_en, input rise_sel, output event_p);
endinterface

// ==== inc/tcr_pkg.sv ====
// Purpose: constants for the 16-bit timer capture/compare register block
// Assumes: byte-wide CPU I/O register port, one I/O clock
// Notes: offsets are data-space byte addresses
// Behaviour
// - With filter on, capture input changes after four equal samples.
// - Edge select zero captures on falling edge, one on rising edge.
// - Capture trigger copies counter into capture register and sets flag.
// - Modes using capture register as top disable the capture input.
// - Clock select 000 stops; 001 to 101 pick divide 1,8,64,256,1024.
// - Clock select 110/111 count external pin falling/rising edges.
// - External pin edges count even when that pin is an output.
// - Force compare strobes act only in non-PWM modes.
// - Force bit one forces a compare match using current output action.
// - Forced match raises no flag and never clears the counter.
// - Force compare bits always read as zero.
// - 16-bit registers use one shared high-byte latch for atomic access.
// - Counter write blocks compare matches on the next timer tick.
// - Compare registers continuously compared; match flags and drives pin.
// - Capture register loads on capture; some modes use it as top.
// - Interrupt mask bits 7 and 6 always read zero.
// - Capture flag clears on vector execution or writing one to it.
// - Capture request needs enable, global enable and capture flag.
package tcr_pkg;
   localparam logic [7:0] ADDR_FLAGS = 8'h36;
   localparam logic [7:0] ADDR_MASK = 8'h6F;
   localparam logic [7:0] ADDR_CTRL_A = 8'h80;
   localparam logic [7:0] ADDR_CTRL_B = 8'h81;
   localparam logic [7:0] ADDR_FORCE = 8'h82;
   localparam logic [7:0] ADDR_CNT_L = 8'h84;
   localparam logic [7:0] ADDR_CNT_H = 8'h85;
   localparam logic [7:0] ADDR_ICR_L = 8'h86;
   localparam logic [7:0] ADDR_ICR_H = 8'h87;
   localparam logic [7:0] ADDR_OCRA_L = 8'h88;
   localparam logic [7:0] ADDR_OCRA_H = 8'h89;
   localparam logic [7:0] ADDR_OCRB_L = 8'h8A;
   localparam logic [7:0] ADDR_OCRB_H = 8'h8B;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [15:0] RESET_WORD = 16'h0000;
   // Writable bit masks
   localparam logic [7:0] MASK_WR_BITS = 8'h27;
   localparam logic [7:0] CTRL_B_WR_BITS = 8'hDF;
   localparam logic [7:0] CTRL_A_WR_BITS = 8'hF3;
   localparam int FILT_BIT = 7;
   localparam int EDGE_BIT = 6;
   localparam int FORCE_A_BIT = 7;
   localparam int FORCE_B_BIT = 6;
   localparam int CAP_BIT = 5;
   localparam int MATCH_B_BIT = 2;
   localparam int MATCH_A_BIT = 1;
   localparam int WRAP_BIT = 0;
   localparam logic [2:0] CS_STOP = 3'h0;
   localparam logic [2:0] CS_DIV1 = 3'h1;
   localparam logic [2:0] CS_DIV8 = 3'h2;
   localparam logic [2:0] CS_DIV64 = 3'h3;
   localparam logic [2:0] CS_DIV256 = 3'h4;
   localparam logic [2:0] CS_DIV1024 = 3'h5;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;
   localparam int PRE_WIDTH = 10;
   localparam logic [9:0] PRE_MASK_8 = 10'h007;
   localparam logic [9:0] PRE_MASK_64 = 10'h03F;
   localparam logic [9:0] PRE_MASK_256 = 10'h0FF;
   localparam logic [9:0] PRE_MASK_1024 = 10'h3FF;
   localparam int FILT_SAMPLES = 4;
   localparam logic [15:0] TOP_8BIT = 16'h00FF;
   localparam logic [15:0] TOP_9BIT = 16'h01FF;
   localparam logic [15:0] TOP_10BIT = 16'h03FF;
   localparam logic [15:0] TOP_MAX = 16'hFFFF;
   localparam logic [1:0] COM_OFF = 2'h0;
   localparam logic [1:0] COM_TOGGLE = 2'h1;
   localparam logic [1:0] COM_CLEAR = 2'h2;
   localparam logic [1:0] COM_SET = 2'h3;
endpackage

// ==== verif/tb_top.sv ====
// Purpose: self-checking bench for the timer register block
// Assumes: read data answers one cycle after the strobe
// Notes: read results are checked against a queue of notes
`define CHK(g, e) begin \
   cmp_count++; \
   if ((g) !== (e)) begin \
      fail_count++; \
      $display("[ERR] t=%0t got %h exp %h", $time, g, e); \
   end \
end
module tb_top import tcr_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_in = 1'b0;
   logic resetn_in = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdat = 8'h00;
   logic [7:0] rdat, a, b, c;
   logic [8:0] n;
   logic [8:0] q[$];
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic gie = 1'b0;
   logic ack = 1'b0;
   logic rd_d = 1'b0;
   logic cap, cnt, pa, pb, irq, ima, imb, iwr;
   logic [15:0] v1, v2, v3;
   logic [31:0] s = 32'hE7BE;
   int fail_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   tcr_timer16 dut_u (.clock_in(clock_in), .resetn_in(resetn_in),
      .io_addr_in(addr), .io_wdata_in(wdat), .io_wr_in(wr), .io_rd_in(rd),
      .io_rdata_out(rdat), .capture_input_pin_in(cap),
      .ext_count_pin_in(cnt), .global_irq_en_in(gie),
      .capture_vec_ack_in(ack), .match_a_vec_ack_in(1'b0),
      .match_b_vec_ack_in(1'b0), .wrap_vec_ack_in(1'b0),
      .capture_irq_out(irq), .match_a_irq_out(ima), .match_b_irq_out(imb),
      .wrap_irq_out(iwr), .compare_output_pin_a_out(pa),
      .compare_output_pin_b_out(pb));
   tcr_pins_model pin_u (.clock_in(clock_in), .cap_out(cap), .cnt_out(cnt));
   initial begin
      forever #2.5 clock_in = ~clock_in;
   end
   function automatic logic [15:0] rnd();
      s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
      return s[15:0];
   endfunction
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge clock_in) begin
      rd_d <= rd;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         tally_and_finish();
      end
   end
   // Oldest note against the answer of each read
   always @(negedge clock_in) begin
      if (rd_d) begin
         n = q.pop_front();
         if (n[8]) `CHK(rdat, n[7:0])
      end
   end
   task automatic wr8(input logic [7:0] ad, input logic [7:0] dt);
      @(negedge clock_in);
      addr = ad;
      wdat = dt;
      wr = 1'b1;
      @(negedge clock_in);
      wr = 1'b0;
   endtask
   task automatic rd8(input logic [7:0] ad, output logic [7:0] v,
                      input logic k, input logic [7:0] e);
      @(negedge clock_in);
      q.push_back({k, e});
      addr = ad;
      rd = 1'b1;
      @(negedge clock_in);
      rd = 1'b0;
      v = rdat;
   endtask
   task automatic ck(input logic [7:0] ad, input logic [7:0] e);
      logic [7:0] v;
      rd8(ad, v, 1'b1, e);
   endtask
   task automatic w16(input logic [7:0] ad, input logic [15:0] v);
      wr8(ad + 8'h01, v[15:8]);
      wr8(ad, v[7:0]);
   endtask
   task automatic c16(input logic [7:0] ad, input logic [15:0] e);
      ck(ad, e[7:0]);
      ck(ad + 8'h01, e[15:8]);
   endtask
   initial begin
      logic [7:0] regs [11] = '{ADDR_MASK, ADDR_CNT_L, ADDR_CNT_H,
         ADDR_ICR_L, ADDR_ICR_H, ADDR_OCRA_L, ADDR_OCRA_H, ADDR_OCRB_L,
         ADDR_OCRB_H, ADDR_CTRL_B, ADDR_FORCE};
      int w [6] = '{8, 2, 16, 128, 512, 2048};
      logic [15:0] cv [3] = '{16'h0010, 16'h000C, 16'hFFFE};
      logic [7:0] fv [3] = '{8'h00, 8'h02, 8'h01};
      repeat (4) @(negedge clock_in);
      resetn_in = 1'b1;
      foreach (regs[i]) ck(regs[i], 8'h00);
      ck(8'h90, 8'h00);
      wr8(ADDR_MASK, 8'hFF);
      ck(ADDR_MASK, 8'h27);
      v1 = rnd();
      v2 = rnd() | 16'h0100;
      w16(ADDR_OCRB_L, v2);
      c16(ADDR_OCRB_L, v2);
      wr8(ADDR_OCRA_H, v1[15:8]);
      wr8(ADDR_CNT_L, v1[7:0]);
      c16(ADDR_CNT_L, v1);
      $display("test registers and latch done");
      for (int k = 0; k < 8; k++) begin
         wr8(ADDR_CTRL_B, 8'(k));
         rd8(ADDR_CNT_L, a, 1'b0, 8'h00);
         if (k < 6) begin
            repeat (w[k] - 2) @(negedge clock_in);
            rd8(ADDR_CNT_L, b, 1'b0, 8'h00);
            `CHK(8'(b - a), (k == 0) ? 8'h00 : 8'h02)
         end else begin
            pin_u.set_cnt(1'b1, 8);
            rd8(ADDR_CNT_L, b, 1'b0, 8'h00);
            pin_u.set_cnt(1'b0, 8);
            rd8(ADDR_CNT_L, c, 1'b0, 8'h00);
            `CHK(8'(b - a), {7'h00, k == 7})
            `CHK(8'(c - b), {7'h00, k == 6})
         end
      end
      $display("test clock select done");
      wr8(ADDR_CTRL_B, 8'h40);
      v1 = rnd();
      w16(ADDR_CNT_L, v1);
      wr8(ADDR_FLAGS, 8'hFF);
      pin_u.set_cap(1'b1, 12);
      c16(ADDR_ICR_L, v1);
      ck(ADDR_FLAGS, 8'h20);
      wr8(ADDR_FLAGS, 8'h20);
      ck(ADDR_FLAGS, 8'h00);
      wr8(ADDR_CTRL_B, 8'h00);
      v2 = rnd();
      w16(ADDR_CNT_L, v2);
      pin_u.set_cap(1'b0, 12);
      c16(ADDR_ICR_L, v2);
      wr8(ADDR_FLAGS, 8'h20);
      pin_u.set_cap(1'b1, 12);
      ck(ADDR_FLAGS, 8'h00);
      wr8(ADDR_MASK, 8'h20);
      wr8(ADDR_CTRL_B, 8'hC0);
      pin_u.set_cap(1'b0, 12);
      pin_u.set_cap(1'b1, 2);
      pin_u.set_cap(1'b0, 12);
      gie = 1'b1;
      ck(ADDR_FLAGS, 8'h00);
      pin_u.set_cap(1'b1, 6);
      `CHK(irq, 1'b0)
      repeat (4) @(negedge clock_in);
      `CHK(irq, 1'b1)
      gie = 1'b0;
      @(negedge clock_in);
      `CHK(irq, 1'b0)
      gie = 1'b1;
      ack = 1'b1;
      @(negedge clock_in);
      ack = 1'b0;
      @(negedge clock_in);
      `CHK(irq, 1'b0)
      wr8(ADDR_CTRL_B, 8'h58);
      v3 = rnd();
      w16(ADDR_CNT_L, v3);
      pin_u.set_cap(1'b0, 12);
      pin_u.set_cap(1'b1, 12);
      c16(ADDR_ICR_L, v2);
      $display("test capture done");
      wr8(ADDR_CTRL_B, 8'h00);
      w16(ADDR_OCRA_L, 16'h0010);
      wr8(ADDR_MASK, 8'h07);
      for (int k = 0; k < 3; k++) begin
         w16(ADDR_CNT_L, cv[k]);
         wr8(ADDR_FLAGS, 8'hFF);
         wr8(ADDR_CTRL_B, {5'h00, CS_DIV1});
         repeat (8) @(negedge clock_in);
         wr8(ADDR_CTRL_B, 8'h00);
         ck(ADDR_FLAGS, fv[k]);
         `CHK({imb, ima, iwr}, fv[k][2:0])
      end
      $display("test compare done");
      wr8(ADDR_FLAGS, 8'hFF);
      wr8(ADDR_CTRL_A, 8'h70);
      wr8(ADDR_FORCE, 8'hC0);
      repeat (2) @(negedge clock_in);
      `CHK({pa, pb}, 2'h3)
      ck(ADDR_FORCE, 8'h00);
      ck(ADDR_FLAGS, 8'h00);
      wr8(ADDR_FORCE, 8'h80);
      repeat (2) @(negedge clock_in);
      `CHK(pa, 1'b0)
      wr8(ADDR_CTRL_A, 8'hC1);
      wr8(ADDR_FORCE, 8'h80);
      repeat (2) @(negedge clock_in);
      `CHK(pa, 1'b0)
      wr8(ADDR_FORCE, 8'h00);
      repeat (2) @(negedge clock_in);
      `CHK(pa, 1'b0)
      $display("test force done");
      tally_and_finish();
   end
endmodule

// ==== verif/tcr_pins_model.sv ====
// Purpose: drives the capture pin and the external count pin
// Assumes: pins change just after a falling clock edge
// Notes: each level holds until the next call
module tcr_pins_model (
   input wire logic clock_in,
   output logic cap_out,
   output logic cnt_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cap_out = 1'b0;
      cnt_out = 1'b0;
   end
   task automatic set_cap(input logic v, input int n);
      @(negedge clock_in);
      cap_out = v;
      repeat (n) @(negedge clock_in);
   endtask
   task automatic set_cnt(input logic v, input int n);
      @(negedge clock_in);
      cnt_out = v;
      repeat (n) @(negedge clock_in);
   endtask
endmodule
